/* design/fpe_flash_page_erase_control.sv */
// Purpose: Control register, interlocks and erase/program sequencing of an embedded flash
// Assumes: Array write port and Avalon-MM slave both run on clk
// Notes: Software keeps the sequence timing; the block keeps the interlocks
`timescale 1ns/1ps
`default_nettype none
module fpe_flash_page_erase_control
   import fpe_pkg::*;
#(
   parameter logic [7:0] PROT_RESET = `FPE_PROT_RESET
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [1:0] avsAddress,
   input wire logic avsRead,
   input wire logic avsWrite,
   input wire logic [31:0] avsWritedata,
   input wire logic [3:0] avsByteenable,
   output logic [31:0] avsReaddata,
   output logic avsWaitrequest,
   input wire fpe_arr_s arrBus,
   output fpe_macro_s macro
);

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   logic rstMeta_n;
   logic rstSync_n;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rstMeta_n <= 1'b0;
         rstSync_n <= 1'b0;
      end
      else
      begin
         rstMeta_n <= 1'b1;
         rstSync_n <= rstMeta_n;
      end
   end

   // ------------------------------------------------------------
   // Address helpers
   // ------------------------------------------------------------
   function automatic logic inVec(input logic [15:0] a);
      return a >= `FPE_VEC_LO;
   endfunction

   function automatic logic inArray(input logic [15:0] a);
      // 3000h user bytes plus 30h vector bytes
      return (a >= `FPE_USER_LO && a <= `FPE_USER_HI) || inVec(a);
   endfunction

   function automatic logic isProtected(input logic [7:0] p, input logic [15:0] a);
      logic [15:0] start;
      start = {`FPE_PROT_TOP, p[7:1], {`FPE_PAGE_BITS{1'b0}}};
      // Protection runs from the start address to the top of the map
      return (p != `FPE_PROT_NONE) && (a >= start);
   endfunction

   function automatic logic [15:0] pageOf(input logic [15:0] a);
      return {a[15:`FPE_PAGE_BITS], {`FPE_PAGE_BITS{1'b0}}};
   endfunction

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   fpe_state_s s;
   fpe_state_s next_s;
   logic busAck;
   logic ctrlWrite;
   logic hvAllowed;
   logic latchNow;
   logic sameRow;
   logic [7:0] wd;

   assign avsReaddata = s.rdata;
   assign avsWaitrequest = s.waitReq;
   assign macro = s.macro;

   always_comb
   begin
      next_s = s;
      wd = avsWritedata[7:0];
      // Request completes on the edge where waitrequest is seen low
      busAck = (avsRead || avsWrite) && !s.waitReq;
      ctrlWrite = avsWrite && busAck && avsByteenable[0]
                  && avsAddress == `FPE_OFS_CTRL;

      // Waitrequest drops for one cycle per request
      next_s.waitReq = !((avsRead || avsWrite) && s.waitReq);
      if ((avsRead || avsWrite) && s.waitReq)
      begin
         unique case (avsAddress)
            `FPE_OFS_CTRL:
               next_s.rdata = {28'h0, s.high_voltage_enable, s.mass, s.erase, s.program_select};
            `FPE_OFS_PROT:
               next_s.rdata = {24'h0, s.protect};
            `FPE_OFS_STAT:
               next_s.rdata = {13'h0, s.latchAddr, s.latched, s.seq};
            default:
               next_s.rdata = 32'h0;
         endcase
      end

      if (avsWrite && busAck && avsByteenable[0] && avsAddress == `FPE_OFS_PROT)
      begin
         next_s.protect = wd;
      end

      // Mass erase touches the whole map, so any protection refuses it
      // The mass bit lands with the same write, so judge the written value
      hvAllowed = (s.erase || s.program_select) && s.seq == FPE_LATCHED
                  && !isProtected(s.protect, s.latchAddr)
                  && !(s.erase && wd[`FPE_BIT_MASS] && s.protect != `FPE_PROT_NONE)
                  && !(s.erase && !wd[`FPE_BIT_MASS] && inVec(s.latchAddr));

      if (ctrlWrite)
      begin
         next_s.mass = wd[`FPE_BIT_MASS];
         // A write asking for both selects leaves them as they were
         if (!(wd[`FPE_BIT_ERASE] && wd[`FPE_BIT_PGM]))
         begin
            next_s.erase = wd[`FPE_BIT_ERASE] && !(s.program_select && wd[`FPE_BIT_PGM]);
            next_s.program_select = wd[`FPE_BIT_PGM] && !(s.erase && wd[`FPE_BIT_ERASE]);
         end
         if (!wd[`FPE_BIT_HIGH_VOLTAGE_ENABLE])
         begin
            next_s.high_voltage_enable = 1'b0;
         end
         else if (!s.high_voltage_enable && hvAllowed)
         begin
            next_s.high_voltage_enable = 1'b1;
         end
      end

      // First array write after a select fixes the target page or row
      latchNow = (s.erase || s.program_select) && !s.latched && arrBus.write && inArray(arrBus.addr);
      if (latchNow)
      begin
         next_s.latched = 1'b1;
         next_s.latchAddr = arrBus.addr;
      end

      // Bytes left at the erased value need no programming pulse
      sameRow = arrBus.addr[15:`FPE_ROW_BITS] == s.latchAddr[15:`FPE_ROW_BITS];
      next_s.macro.progStrobe = s.program_select && s.high_voltage_enable && s.latched && arrBus.write
                                && sameRow && arrBus.wdata != `FPE_ERASED_BYTE;
      if (next_s.macro.progStrobe)
      begin
         next_s.macro.progAddr = arrBus.addr;
         next_s.macro.progData = arrBus.wdata;
      end

      // Latch is forgotten once both selects are clear and the pump is off
      if (!next_s.erase && !next_s.program_select && !next_s.high_voltage_enable)
      begin
         next_s.latched = 1'b0;
      end

      if (!next_s.erase && !next_s.program_select && !next_s.high_voltage_enable)
      begin
         next_s.seq = FPE_IDLE;
      end
      else if (next_s.high_voltage_enable)
      begin
         next_s.seq = FPE_HIGHV;
      end
      else if (next_s.latched)
      begin
         next_s.seq = FPE_LATCHED;
      end
      else
      begin
         next_s.seq = FPE_SELECTED;
      end

      next_s.macro.pumpOn = next_s.high_voltage_enable;
      next_s.macro.eraseMass = next_s.high_voltage_enable && next_s.erase && next_s.mass;
      next_s.macro.erasePage = next_s.high_voltage_enable && next_s.erase && !next_s.mass
                               && !inVec(next_s.latchAddr);
      next_s.macro.pageBase = pageOf(next_s.latchAddr);
   end

   always_ff @(posedge clk or negedge rstSync_n)
   begin
      if (!rstSync_n)
      begin
         s <= '0;
         s.protect <= PROT_RESET;
         s.waitReq <= 1'b1;
      end
      else
      begin
         s <= next_s;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstSync_n);

   sequence seqLatchWrite;
      (s.erase || s.program_select) && !s.latched && arrBus.write && inArray(arrBus.addr);
   endsequence

   sequence seqRowWrite;
      s.program_select && s.high_voltage_enable && s.latched && arrBus.write && sameRow
      && arrBus.wdata != `FPE_ERASED_BYTE;
   endsequence

   sequence seqHvRise;
      !s.high_voltage_enable ##1 s.high_voltage_enable;
   endsequence

   AST_NO_BOTH_SELECT: assert property (!(s.erase && s.program_select))
      else $error("erase and program selected together");

   AST_HV_NEEDS_SELECT: assert property (seqHvRise |-> $past(s.erase || s.program_select))
      else $error("high voltage without a selected operation");

   AST_HV_NEEDS_LATCH: assert property (seqHvRise |-> $past(s.seq) == FPE_LATCHED)
      else $error("high voltage before the address latch");

   AST_HV_NOT_PROTECTED: assert property
      (seqHvRise |-> !isProtected(s.protect, s.latchAddr))
      else $error("high voltage on a protected address");

   AST_PAGE_NOT_VECTORS: assert property (macro.erasePage |-> !inVec(s.latchAddr))
      else $error("page erase aimed at the vector page");

   AST_PAGE_ALIGNED: assert property
      (macro.erasePage |-> macro.pageBase[`FPE_PAGE_BITS-1:0] == '0)
      else $error("page base not aligned");

   AST_MASS_PICK: assert property
      (s.erase && s.high_voltage_enable |-> macro.eraseMass == s.mass && macro.erasePage != s.mass
       || inVec(s.latchAddr))
      else $error("mass select not steering erase kind");

   AST_LATCH_ADDR: assert property
      (seqLatchWrite |=> s.latched && s.latchAddr == $past(arrBus.addr))
      else $error("first array write not latched");

   AST_ROW_PROGRAM: assert property
      (seqRowWrite |=> macro.progStrobe && macro.progAddr == $past(arrBus.addr))
      else $error("row write did not program its byte");

   AST_PUMP_OFF: assert property (!s.high_voltage_enable |-> !macro.pumpOn ##1 1'b1)
      else $error("pump on while high voltage disabled");

   // ------------------------------------------------------------
   // Bus, interlock and output checks
   // ------------------------------------------------------------
   sequence seqBusRequest;
      (avsRead || avsWrite) && s.waitReq;
   endsequence

   sequence seqBothSelects;
      ctrlWrite && wd[`FPE_BIT_ERASE] && wd[`FPE_BIT_PGM];
   endsequence

   sequence seqForeignWrite;
      (s.erase || s.program_select) && !s.latched && arrBus.write && !inArray(arrBus.addr);
   endsequence

   // Master counts on a single answer cycle before its next request
   AST_WAIT_ONE_CYCLE: assert property (seqBusRequest |=> !s.waitReq ##1 s.waitReq)
      else $error("waitrequest not low for exactly one cycle");

   AST_RESET_CLEARS: assert property (@(posedge clk) disable iff (1'b0)
      !rstSync_n |-> !(s.high_voltage_enable || s.mass || s.erase || s.program_select) && macro == '0)
      else $error("control bits not clear in reset");

   AST_PUMP_FOLLOWS: assert property (macro.pumpOn == s.high_voltage_enable)
      else $error("pump output differs from high voltage bit");

   AST_HV_BY_WRITE: assert property (seqHvRise |-> $past(ctrlWrite))
      else $error("high voltage rose without a control write");

   AST_BOTH_KEEP: assert property
      (seqBothSelects |=> s.erase == $past(s.erase) && s.program_select == $past(s.program_select))
      else $error("write of both selects changed them");

   AST_NO_FOREIGN_LATCH: assert property (seqForeignWrite |=> !s.latched)
      else $error("write outside the array latched an address");

   AST_ERASED_NO_STROBE: assert property
      (arrBus.write && arrBus.wdata == `FPE_ERASED_BYTE |=> !macro.progStrobe)
      else $error("erased value produced a program pulse");

   AST_MASS_NEEDS_BITS: assert property
      (macro.eraseMass |-> s.mass && s.erase && s.high_voltage_enable)
      else $error("mass erase without its control bits");

   AST_ERASE_SETS: assert property
      (ctrlWrite && wd[`FPE_BIT_ERASE] && !wd[`FPE_BIT_PGM] && !s.program_select |=> s.erase)
      else $error("erase select write not taken");

   AST_PGM_SETS: assert property
      (ctrlWrite && wd[`FPE_BIT_PGM] && !wd[`FPE_BIT_ERASE] && !s.erase |=> s.program_select)
      else $error("program select write not taken");

   AST_CTRL_READBACK: assert property
      (avsRead && s.waitReq && avsAddress == `FPE_OFS_CTRL
       |=> avsReaddata[3:0] == $past({s.high_voltage_enable, s.mass, s.erase, s.program_select}))
      else $error("control readback differs from the bits");

   AST_ROW_OUTSIDE: assert property
      (arrBus.write && !sameRow |=> !macro.progStrobe)
      else $error("program pulse outside the latched row");

   AST_MASS_UNPROTECTED: assert property
      (seqHvRise |-> !(s.erase && s.mass) || s.protect == `FPE_PROT_NONE)
      else $error("mass erase high voltage under protection");

endmodule // fpe_flash_page_erase_control
`default_nettype wire

/* design/fpe_defines.svh */
// Purpose: Named offsets, fields and values of the flash page erase control block
// Assumes: Included by the package file and the testbench
// Notes: Word addresses of the registers on the Avalon-MM slave
`ifndef FPE_DEFINES_SVH
`define FPE_DEFINES_SVH
`define FPE_OFS_CTRL 2'h0
`define FPE_OFS_PROT 2'h1
`define FPE_OFS_STAT 2'h2
`define FPE_BIT_HIGH_VOLTAGE_ENABLE 3
`define FPE_BIT_MASS 2
`define FPE_BIT_ERASE 1
`define FPE_BIT_PGM 0
`define FPE_PROT_RESET 8'hff
`define FPE_PROT_NONE 8'hff
`define FPE_USER_LO 16'hc000
`define FPE_USER_HI 16'hefff
`define FPE_VEC_LO 16'hffd0
`define FPE_PAGE_BITS 7
`define FPE_ROW_BITS 6
`define FPE_ERASED_BYTE 8'hff
`define FPE_PROT_TOP 2'h3
`endif

/* design/fpe_pkg.sv */
// Purpose: Types shared by the flash page erase control block
// Assumes: fpe_defines.svh holds all numeric constants except the fpe_seq_e state encodings
// Notes: Module state apart from the reset synchronizer is one packed struct
`include "fpe_defines.svh"
package fpe_pkg;
   typedef enum logic [1:0]
   {
      FPE_IDLE = 2'h0,
      FPE_SELECTED = 2'h1,
      FPE_LATCHED = 2'h3,
      FPE_HIGHV = 2'h2
   } fpe_seq_e;

   typedef struct packed
   {
      logic [15:0] addr;
      logic write;
      logic [7:0] wdata;
   } fpe_arr_s;

   typedef struct packed
   {
      logic pumpOn;
      logic eraseMass;
      logic erasePage;
      logic [15:0] pageBase;
      logic progStrobe;
      logic [15:0] progAddr;
      logic [7:0] progData;
   } fpe_macro_s;

   typedef struct packed
   {
      logic high_voltage_enable;
      logic mass;
      logic erase;
      logic program_select;
      logic [7:0] protect;
      fpe_seq_e seq;
      logic latched;
      logic [15:0] latchAddr;
      logic waitReq;
      logic [31:0] rdata;
      fpe_macro_s macro;
   } fpe_state_s;
endpackage

/* verif/tb.sv */
// Purpose: Self-checking bench of the flash page erase control block
// Assumes: Avalon-MM slave answers with one cycle of waitrequest low
// Notes: Software timing of the sequences is not modelled, the block does not check it
`timescale 1ns/1ps
`default_nettype none
`include "fpe_defines.svh"
module tb
   import fpe_pkg::*;
;
   localparam logic [1:0] CTRL = `FPE_OFS_CTRL;
   localparam logic [1:0] PROT = `FPE_OFS_PROT;
   localparam logic [1:0] STAT = `FPE_OFS_STAT;
   logic clk;
   logic rst_n;
   logic [1:0] avsAddress;
   logic avsRead;
   logic avsWrite;
   logic [31:0] avsWritedata;
   logic [3:0] avsByteenable;
   logic [31:0] avsReaddata;
   logic avsWaitrequest;
   fpe_arr_s arrBus;
   fpe_macro_s macro;
   logic [31:0] rd;
   logic sawStrobe;
   logic [15:0] strobeAddr;
   logic [7:0] strobeData;
   int nErrors;
   int comparisons;

   fpe_flash_page_erase_control #(.PROT_RESET(8'hff)) fpe_flash_page_erase_control_inst
   (
      .clk(clk),
      .rst_n(rst_n),
      .avsAddress(avsAddress),
      .avsRead(avsRead),
      .avsWrite(avsWrite),
      .avsWritedata(avsWritedata),
      .avsByteenable(avsByteenable),
      .avsReaddata(avsReaddata),
      .avsWaitrequest(avsWaitrequest),
      .arrBus(arrBus),
      .macro(macro)
   );

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ----------------------------------------
   // Access and compare tasks
   // ----------------------------------------
   task automatic finish_test();
      $display("errors %0d comparisons %0d", nErrors, comparisons);
      if (nErrors == 0 && comparisons > 0)
      begin
         $display("verification passed");
      end
      else
      begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         nErrors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Holds the request until waitrequest is sampled low, then releases it
   task automatic bus(input logic [1:0] a, input logic w, input logic [7:0] d,
      input logic [3:0] be);
      int i;
      @(posedge clk);
      avsAddress <= a;
      avsWrite <= w;
      avsRead <= !w;
      avsWritedata <= {24'h0, d};
      avsByteenable <= be;
      for (i = 0; i < 20; i++)
      begin
         @(posedge clk);
         if (avsWaitrequest === 1'b0)
         begin
            break;
         end
      end
      if (i == 20)
      begin
         nErrors++;
         finish_test();
      end
      rd = avsReaddata;
      avsRead <= 1'b0;
      avsWrite <= 1'b0;
   endtask

   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      bus(a, 1'b1, d, 4'hf);
   endtask

   task automatic rdchk(input logic [1:0] a, input logic [31:0] exp);
      bus(a, 1'b0, 8'h0, 4'hf);
      chk(rd, exp);
   endtask

   // Macro outputs update on the same edge as the control register bits
   task automatic mchk(input logic [2:0] exp);
      repeat (2) @(posedge clk);
      #1;
      chk({29'h0, macro.pumpOn, macro.eraseMass, macro.erasePage}, {29'h0, exp});
   endtask

   // One-cycle byte write toward the array; watches for a program strobe
   task automatic arr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      arrBus <= '{a, 1'b1, d};
      @(posedge clk);
      arrBus.write <= 1'b0;
      sawStrobe = 1'b0;
      repeat (3)
      begin
         #1;
         if (macro.progStrobe === 1'b1)
         begin
            sawStrobe = 1'b1;
            strobeAddr = macro.progAddr;
            strobeData = macro.progData;
         end
         @(posedge clk);
      end
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      rst_n = 1'b0;
      avsAddress = 2'h0;
      avsRead = 1'b0;
      avsWrite = 1'b0;
      avsWritedata = 32'h0;
      avsByteenable = 4'hf;
      arrBus = '0;
      nErrors = 0;
      comparisons = 0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rdchk(CTRL, 32'h0);
      mchk(3'h0);
      rdchk(PROT, 32'hff);
      rdchk(2'h3, 32'h0);
      wr(CTRL, 8'h03);
      rdchk(CTRL, 32'h0);
      wr(CTRL, 8'h02);
      rdchk(CTRL, 32'h2);
      wr(CTRL, 8'h03);
      rdchk(CTRL, 32'h2);
      wr(CTRL, 8'h0a);
      rdchk(CTRL, 32'h2);
      arr(16'h1000, 8'h00);
      rdchk(STAT, 32'h1);
      arr(16'hc085, 8'h00);
      rdchk(STAT, {13'h0, 16'hc085, 3'h7});
      wr(CTRL, 8'h0a);
      rdchk(CTRL, 32'ha);
      mchk(3'h5);
      chk({16'h0, macro.pageBase}, 32'hc080);
      wr(CTRL, 8'h08);
      wr(CTRL, 8'h00);
      mchk(3'h0);
      wr(CTRL, 8'h02);
      arr(16'hffd5, 8'h00);
      wr(CTRL, 8'h0a);
      rdchk(CTRL, 32'h2);
      wr(CTRL, 8'h00);
      wr(CTRL, 8'h06);
      arr(16'hffd5, 8'h00);
      wr(CTRL, 8'h0e);
      mchk(3'h6);
      wr(CTRL, 8'h0c);
      wr(CTRL, 8'h00);
      wr(PROT, 8'h00);
      wr(CTRL, 8'h02);
      arr(16'hc000, 8'h00);
      wr(CTRL, 8'h0a);
      rdchk(CTRL, 32'h2);
      wr(CTRL, 8'h00);
      wr(PROT, 8'hff);
      wr(CTRL, 8'h01);
      arr(16'hc040, 8'h00);
      wr(CTRL, 8'h09);
      rdchk(CTRL, 32'h9);
      wr(CTRL, 8'h0b);
      rdchk(CTRL, 32'h9);
      arr(16'hc041, 8'h5a);
      chk({15'h0, sawStrobe, strobeAddr}, 32'h1c041);
      chk({24'h0, strobeData}, 32'h5a);
      arr(16'hc041, 8'hff);
      chk({31'h0, sawStrobe}, 32'h0);
      arr(16'hc080, 8'h00);
      chk({31'h0, sawStrobe}, 32'h0);
      wr(CTRL, 8'h08);
      wr(CTRL, 8'h00);
      mchk(3'h0);
      bus(CTRL, 1'b1, 8'h02, 4'he);
      rdchk(CTRL, 32'h0);
      finish_test();
   end
endmodule // tb
`default_nettype wire
